//--- rtl/frws_pkg.sv
// Constants and carrier types of the flash row write sequencer
//
// Overview of operation
// R1: Flash is programmed only as whole rows of 32 words, that is 64 bytes.
// R2: No word or byte goes to flash directly; every program passes through the holding row.
// R3: Sixty-four byte-wide holding registers, loaded by table writes, supply the row data.
// R4: The staging latch is one byte, so a full row takes up to 64 table writes.
// R5: A table write is a short write that updates one holding register and never the array.
// R6: After loading, the core writes the control register to launch the long write.
// R7: Instruction execution is held off for the whole long write.
// R8: The long write ends when the on-chip programming timer runs out.
// R9: Every holding register reads FFh after reset and after each finished write.
// R10: A holding register at FFh leaves its flash byte unchanged.
// R11: Programming only clears bits; a zero in the array never becomes one.
// R12: The core may start a write after loading only the holding registers it changes.
// R13: A start counts only after the key bytes 55h then 0AAh; otherwise it is ignored.
// R14: The stall lasts the whole timed row write of about 2 ms.
// R15: The core keeps the row pointer inside the target row before starting.
// R16: The core sets write enable, selects program memory and clears config select first.
// R17: The start bit clears itself when the timer ends the long write.
package frws_pkg;

   // ------------------------------------------------------------
   // Row geometry
   // ------------------------------------------------------------
   localparam int ROW_WORDS = 32;
   localparam int ROW_BYTES = 2 * ROW_WORDS;
   localparam int IDX_W = 6;
   localparam int PTR_W = 22;
   localparam int ROW_W = PTR_W - IDX_W;
   localparam logic [7:0] HOLD_ERASED = 8'hff;

   // ------------------------------------------------------------
   // Control register fields and unlock keys
   // ------------------------------------------------------------
   localparam int CTRL_PGM_SEL_BIT = 7;
   localparam int CTRL_CFG_SEL_BIT = 6;
   localparam int CTRL_WRITE_ENABLE_BIT_BIT = 2;
   localparam int CTRL_START_BIT = 1;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] CTRL_SW_MASK = 8'hc4;
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;

   // ------------------------------------------------------------
   // Programming time
   // ------------------------------------------------------------
   localparam int PROG_TIME_NS = 2000000;
   localparam int CLK_PERIOD_NS = 5;
   localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic stb;
      logic [PTR_W-1:0] ptr;
      logic [7:0] data;
   } frws_tw_t;

   typedef struct packed {
      logic ctrl_stb;
      logic key_stb;
      logic [7:0] data;
   } frws_reg_wr_t;

endpackage : frws_pkg

//--- rtl/frws_hold_buf.sv
// Row holding buffer: one byte per table write, bulk return to erased value
`timescale 1ns/10ps
module frws_hold_buf #(
   parameter int DEPTH = frws_pkg::ROW_BYTES,
   parameter int AW = frws_pkg::IDX_W
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Byte write port
   input wire logic wr_i,
   input wire logic [AW-1:0] idx_i,
   input wire logic [7:0] data_i,
   // Bulk erase after a finished write
   input wire logic erase_i,
   // Whole row, byte 0 in the low bits
   output logic [8*DEPTH-1:0] row_o
);
   import frws_pkg::*;

   logic [7:0] mem_r [DEPTH];

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rstn_i || erase_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] <= HOLD_ERASED; // R9
         end
      end else if (wr_i) begin
         mem_r[idx_i] <= data_i; // R3 R4 R5
      end
   end

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_pack
         assign row_o[8*g +: 8] = mem_r[g];
      end
   endgenerate

endmodule : frws_hold_buf

//--- rtl/frws_prog_timer.sv
// Programming timer: counts out one long write and flags its end
`timescale 1ns/10ps
module frws_prog_timer #(
   parameter int CYCLES = frws_pkg::PROG_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Control
   input wire logic start_i,
   // Status
   output logic busy_o,
   output logic done_o
);
   import frws_pkg::*;

   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);

   logic [CW-1:0] cnt_r;
   logic run_r;

   // ------------------------------------------------------------
   // Down counter
   // ------------------------------------------------------------
   assign done_o = run_r && (cnt_r == '0); // R8
   assign busy_o = run_r;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         run_r <= 1'b0;
         cnt_r <= '0;
      end else if (start_i && !run_r) begin
         run_r <= 1'b1;
         cnt_r <= LOAD;
      end else if (done_o) begin
         run_r <= 1'b0;
      end else if (run_r) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

endmodule : frws_prog_timer

//--- rtl/frws_top.sv
// Flash row write sequencer: holding row, unlock keys, timed long write
`timescale 1ns/10ps
module frws_top #(
   parameter int PROG_CYCLES = frws_pkg::PROG_CYCLES
) (
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic RSTN_I,
   // Table write from the core
   input frws_pkg::frws_tw_t TW_I,
   // Control and key register writes from the core
   input frws_pkg::frws_reg_wr_t REG_WR_I,
   // Control register read back
   output logic [7:0] CTRL_O,
   // Core stall
   output logic STALL_O,
   // Flash array program port
   output logic PROG_O,
   output logic [frws_pkg::ROW_W-1:0] PROG_ROW_O,
   output logic [8*frws_pkg::ROW_BYTES-1:0] PROG_CLR_O
);
   import frws_pkg::*;

   // ------------------------------------------------------------
   // Types and state
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      KEY_LOCKED,
      KEY_HALF,
      KEY_OPEN
   } frws_key_t;

   typedef enum logic {
      ST_IDLE,
      ST_PROG
   } frws_st_t;

   frws_key_t key_r;
   frws_key_t key_nxt;
   frws_st_t st_r;
   frws_st_t st_nxt;

   logic [7:0] ctrl_r;
   logic [7:0] ctrl_nxt;
   logic stall_r;
   logic prog_r;
   logic [ROW_W-1:0] row_r;
   logic [8*ROW_BYTES-1:0] clr_r;

   logic [8*ROW_BYTES-1:0] hold_row;
   logic tmr_busy;
   logic tmr_done;

   // ------------------------------------------------------------
   // Request decode
   // ------------------------------------------------------------
   // Table writes arriving during a long write are dropped; the core
   // is stalled then, so only a misbehaving master can hit this.
   wire tw_acc = TW_I.stb && (st_r == ST_IDLE);
   wire [IDX_W-1:0] tw_idx = TW_I.ptr[IDX_W-1:0];
   wire ctrl_wr = REG_WR_I.ctrl_stb && (st_r == ST_IDLE);
   wire key_wr = REG_WR_I.key_stb && (st_r == ST_IDLE);
   wire [7:0] wdata = REG_WR_I.data;

   wire req_start = ctrl_wr && wdata[CTRL_START_BIT];
   wire setup_ok = wdata[CTRL_WRITE_ENABLE_BIT_BIT] && wdata[CTRL_PGM_SEL_BIT]
                   && !wdata[CTRL_CFG_SEL_BIT];
   wire start_acc = req_start && setup_ok && (key_r == KEY_OPEN); // R13 R6
   wire prog_end = (st_r == ST_PROG) && tmr_done; // R8

   // ------------------------------------------------------------
   // Holding buffer and timer
   // ------------------------------------------------------------
   frws_hold_buf #(
      .DEPTH(ROW_BYTES),
      .AW(IDX_W)
   ) i_frws_hold_buf (
      .clk_i(REF_CLK_I),
      .rstn_i(RSTN_I),
      .wr_i(tw_acc),
      .idx_i(tw_idx),
      .data_i(TW_I.data),
      .erase_i(prog_end),
      .row_o(hold_row)
   );

   frws_prog_timer #(
      .CYCLES(PROG_CYCLES)
   ) i_frws_prog_timer (
      .clk_i(REF_CLK_I),
      .rstn_i(RSTN_I),
      .start_i(start_acc),
      .busy_o(tmr_busy),
      .done_o(tmr_done)
   );

   // ------------------------------------------------------------
   // Unlock key sequence
   // ------------------------------------------------------------
   // Any control write consumes the unlock, so a second start needs
   // a fresh key pair; a wrong key byte relocks.
   always_comb begin
      key_nxt = key_r;
      if (ctrl_wr) begin
         key_nxt = KEY_LOCKED;
      end else if (key_wr) begin
         if (wdata == KEY_FIRST) begin
            key_nxt = KEY_HALF;
         end else if (wdata == KEY_SECOND && key_r == KEY_HALF) begin
            key_nxt = KEY_OPEN; // R13
         end else begin
            key_nxt = KEY_LOCKED;
         end
      end
   end

   // ------------------------------------------------------------
   // Control register
   // ------------------------------------------------------------
   // Software writes only the select and enable bits; the start bit is
   // set by an accepted request and cleared only by the timer.
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (ctrl_wr) begin
         ctrl_nxt = (ctrl_r & ~CTRL_SW_MASK) | (wdata & CTRL_SW_MASK);
      end
      if (start_acc) begin
         ctrl_nxt[CTRL_START_BIT] = 1'b1;
      end
      if (prog_end) begin
         ctrl_nxt[CTRL_START_BIT] = 1'b0; // R17
      end
   end

   // ------------------------------------------------------------
   // Long write sequence
   // ------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ST_IDLE: begin
            if (start_acc) begin
               st_nxt = ST_PROG;
            end
         end
         ST_PROG: begin
            if (prog_end) begin
               st_nxt = ST_IDLE;
            end
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         key_r <= KEY_LOCKED;
         st_r <= ST_IDLE;
         ctrl_r <= CTRL_RST;
      end else begin
         key_r <= key_nxt;
         st_r <= st_nxt;
         ctrl_r <= ctrl_nxt;
      end
   end

   // Stall and array strobe follow the state so both span the whole
   // timed write and drop together at the edge that ends the timer's last cycle.
   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         stall_r <= 1'b0;
         prog_r <= 1'b0;
      end else begin
         stall_r <= (st_nxt == ST_PROG); // R7 R14
         prog_r <= (st_nxt == ST_PROG); // R1 R2
      end
   end

   // The array is told which bits to clear, never which to set: an
   // erased holding byte asks for nothing and a zero cannot rise.
   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         row_r <= '0;
         clr_r <= '0;
      end else if (start_acc) begin
         row_r <= TW_I.ptr[PTR_W-1:IDX_W];
         clr_r <= ~hold_row; // R10 R11 R12
      end else if (prog_end) begin
         clr_r <= '0;
      end
   end

   assign CTRL_O = ctrl_r;
   assign STALL_O = stall_r;
   assign PROG_O = prog_r;
   assign PROG_ROW_O = row_r;
   assign PROG_CLR_O = clr_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (!RSTN_I);

   localparam logic [7:0] CTRL_RD_MASK = CTRL_SW_MASK | (8'h01 << CTRL_START_BIT);

   // A long write spans far more cycles than a repetition may count,
   // so its length is judged on this counter instead.
   int stall_cnt;
   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I || !stall_r) begin
         stall_cnt <= 0;
      end else begin
         stall_cnt <= stall_cnt + 1;
      end
   end

   // The core leaves one quiet cycle between register writes, so the
   // pair is matched at that spacing; wider gaps are not covered here.
   sequence s_quiet_bus;
      !ctrl_wr && !key_wr;
   endsequence

   sequence s_key_pair;
      (key_wr && wdata == KEY_FIRST) ##1 s_quiet_bus ##1 (key_wr && wdata == KEY_SECOND);
   endsequence

   sequence s_start_ok;
      ctrl_wr && wdata[CTRL_START_BIT] && setup_ok;
   endsequence

   a_unlock_start: assert property ( // R13
      s_key_pair ##1 s_quiet_bus ##1 s_start_ok |=> STALL_O
   ) else $error("Unlocked start did not stall the core");

   a_locked_ignore: assert property ( // R13
      (key_r == KEY_LOCKED && req_start && !STALL_O) |=> !STALL_O && !PROG_O
   ) else $error("Start without key pair was taken");

   a_stall_hold: assert property ( // R7
      $rose(STALL_O) |-> (STALL_O && PROG_O) [*8]
   ) else $error("Stall dropped early in a long write");

   a_prog_length: assert property ( // R14
      $fell(STALL_O) |-> stall_cnt == PROG_CYCLES
   ) else $error("Long write length differs from timer count");

   a_timer_end: assert property ( // R8
      (STALL_O && tmr_done) |=> !STALL_O && !tmr_busy
   ) else $error("Timer end did not finish the long write");

   a_start_autoclr: assert property ( // R17
      $fell(STALL_O) |-> !CTRL_O[CTRL_START_BIT] && $past(CTRL_O[CTRL_START_BIT])
   ) else $error("Start bit not cleared by the timer");

   a_hold_erased: assert property ( // R9
      $fell(STALL_O) |-> hold_row == {ROW_BYTES{HOLD_ERASED}}
   ) else $error("Holding row not erased after write");

   a_clear_only: assert property ( // R10
      start_acc |=> PROG_CLR_O == ~$past(hold_row) && PROG_O
   ) else $error("Array clear mask does not match holding row");

   a_short_write: assert property ( // R5
      (tw_acc && !start_acc) |=> $stable(PROG_O) && $stable(PROG_CLR_O)
      && hold_row[8*$past(tw_idx) +: 8] == $past(TW_I.data)
   ) else $error("Table write did not land in its holding byte only");

   a_busy_refuse: assert property ( // R7
      (STALL_O && TW_I.stb && !tmr_done) |=> $stable(hold_row)
   ) else $error("Table write changed the row during a long write");

   a_row_taken: assert property ( // R1
      start_acc |=> PROG_ROW_O == $past(TW_I.ptr[PTR_W-1:IDX_W])
   ) else $error("Programmed row differs from pointer at start");

   a_idle_mask: assert property ( // R2
      !PROG_O |-> PROG_CLR_O == '0
   ) else $error("Clear mask shown outside a long write");

   a_ctrl_reserved: assert property ( // R6
      (CTRL_O & ~CTRL_RD_MASK) == 8'h00
   ) else $error("Unused control bits are not zero");

   a_key_relock: assert property ( // R13
      (key_r == KEY_HALF && ctrl_wr) |=> key_r == KEY_LOCKED
   ) else $error("Control write did not relock the key");

endmodule : frws_top

//--- test/frws_core_model.sv
// Core model: issues table writes, key bytes and control writes
`timescale 1ns/10ps
module frws_core_model (
   // Clock and stall
   input wire logic clk_i,
   input wire logic stall_i,
   // Requests to the sequencer
   output frws_pkg::frws_tw_t tw_o,
   output frws_pkg::frws_reg_wr_t reg_o
);
   import frws_pkg::*;
   logic hang;
   initial begin
      tw_o = '0;
      reg_o = '0;
      hang = 1'b0;
   end
   // ---------------------------------------------
   // Requests
   // ---------------------------------------------
   // A real core issues nothing while stalled
   task automatic wait_free();
      int n;
      n = 0;
      while (stall_i === 1'b1 && n < 1000) begin
         @(posedge clk_i);
         n++;
      end
      if (n == 1000) hang = 1'b1;
   endtask : wait_free
   // Data is inverted once released so a stale byte is never mistaken for valid
   task automatic tw(input logic [PTR_W-1:0] p, input logic [7:0] d, input bit force_it);
      @(posedge clk_i);
      if (!force_it) wait_free();
      tw_o <= '{stb: 1'b1, ptr: p, data: d};
      @(posedge clk_i);
      tw_o.stb <= 1'b0;
      tw_o.data <= ~d;
   endtask : tw
   task automatic wr(input bit is_ctrl, input logic [7:0] d);
      @(posedge clk_i);
      wait_free();
      reg_o <= '{ctrl_stb: is_ctrl, key_stb: !is_ctrl, data: d};
      @(posedge clk_i);
      reg_o.ctrl_stb <= 1'b0;
      reg_o.key_stb <= 1'b0;
      reg_o.data <= ~d;
   endtask : wr
   // Start may follow a partial load of the row
   task automatic start(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] c);
      wr(1'b0, k1);
      wr(1'b0, k2);
      wr(1'b1, c);
   endtask : start
endmodule : frws_core_model

//--- test/frws_top_test.sv
// Self-checking bench of the flash row write sequencer
`timescale 1ns/10ps
module frws_top_test;
   import frws_pkg::*;
   localparam int CYC = 20;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   frws_tw_t tw;
   frws_reg_wr_t reg_wr;
   logic [7:0] ctrl;
   logic stall;
   logic prog;
   logic [ROW_W-1:0] prow;
   logic [8*ROW_BYTES-1:0] clr;
   logic [7:0] hold [ROW_BYTES];
   int fail_count = 0;
   int comparisons = 0;
   int stall_cnt = 0;
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (stall === 1'b1) stall_cnt++;
   frws_top #(.PROG_CYCLES(CYC)) i_frws_top (.REF_CLK_I(ref_clk), .RSTN_I(rstn), .TW_I(tw),
      .REG_WR_I(reg_wr), .CTRL_O(ctrl), .STALL_O(stall), .PROG_O(prog),
      .PROG_ROW_O(prow), .PROG_CLR_O(clr));
   frws_core_model i_frws_core_model (.clk_i(ref_clk), .stall_i(stall), .tw_o(tw),
      .reg_o(reg_wr));
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   task automatic check(input logic [8*ROW_BYTES-1:0] seen, input logic [8*ROW_BYTES-1:0] exp,
         input string what);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask : check
   task automatic test_done();
      check(i_frws_core_model.hang, 1'b0, "core hung");
      $display("fails %0d of %0d compares", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   function automatic logic [8*ROW_BYTES-1:0] exp_clr();
      logic [8*ROW_BYTES-1:0] r;
      for (int n = 0; n < ROW_BYTES; n++) r[8*n+:8] = ~hold[n];
      return r;
   endfunction : exp_clr
   task automatic erase_model();
      for (int n = 0; n < ROW_BYTES; n++) hold[n] = HOLD_ERASED;
   endtask : erase_model
   // Launch, check the long write and its end
   task automatic launch(input logic [ROW_W-1:0] row);
      int n;
      stall_cnt = 0;
      i_frws_core_model.start(KEY_FIRST, KEY_SECOND, 8'h86);
      #1;
      check(stall, 1'b1, "no stall");
      check(prog, 1'b1, "no program");
      check(ctrl, 8'h86, "ctrl busy");
      check(prow, row, "row");
      check(clr, exp_clr(), "clear mask");
      // Ignored while busy, and erased at the end anyway
      i_frws_core_model.tw({row, 6'h03}, 8'h00, 1'b1);
      n = 0;
      while (stall === 1'b1 && n < 1000) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (n == 1000) begin
         fail_count++;
         test_done();
      end
      check(stall_cnt, CYC, "stall length");
      check(ctrl, 8'h84, "start bit");
      check(prog, 1'b0, "idle program strobe");
      check(clr, '0, "idle clear mask");
      erase_model();
   endtask : launch
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic test_reset();
      check({ctrl, stall, prog, prow}, '0, "reset outputs");
      check(clr, '0, "reset clear mask");
      $display("test reset done");
   endtask : test_reset
   task automatic test_full_row();
      logic [7:0] d;
      for (int n = 0; n < ROW_BYTES; n++) begin
         d = (n == 7) ? 8'hff : 8'(n * 3);
         i_frws_core_model.tw({16'h1234, 6'(n)}, d, 1'b0);
         hold[n] = d;
      end
      launch(16'h1234);
      $display("test full row done");
   endtask : test_full_row
   task automatic test_partial();
      i_frws_core_model.tw({16'h0a5c, 6'h00}, 8'h0f, 1'b0);
      i_frws_core_model.tw({16'h0a5c, 6'h01}, 8'hf0, 1'b0);
      hold[0] = 8'h0f;
      hold[1] = 8'hf0;
      launch(16'h0a5c);
      $display("test partial done");
   endtask : test_partial
   task automatic test_refused();
      logic [7:0] k1 [6] = '{8'h55, 8'haa, 8'h55, 8'h55, 8'h55, 8'h55};
      logic [7:0] k2 [6] = '{8'h55, 8'h55, 8'haa, 8'haa, 8'haa, 8'h33};
      logic [7:0] cv [6] = '{8'h86, 8'h86, 8'h82, 8'hc6, 8'h06, 8'h86};
      for (int i = 0; i < 6; i++) begin
         i_frws_core_model.start(k1[i], k2[i], cv[i]);
         #1;
         check({stall, prog}, 2'b00, "start taken");
         check(ctrl, cv[i] & CTRL_SW_MASK, "ctrl value");
      end
      $display("test refused done");
   endtask : test_refused
   task automatic test_mid_reset();
      i_frws_core_model.tw({16'h0001, 6'h05}, 8'h00, 1'b0);
      @(posedge ref_clk);
      rstn <= 1'b0;
      @(posedge ref_clk);
      rstn <= 1'b1;
      #1;
      check({ctrl, stall}, '0, "reset ctrl");
      launch(16'h0001);
      $display("test mid reset done");
   endtask : test_mid_reset
   initial begin
      erase_model();
      repeat (10) @(posedge ref_clk);
      rstn <= 1'b1;
      #1;
      test_reset();
      test_full_row();
      test_partial();
      test_refused();
      test_mid_reset();
      test_done();
   end
   initial begin
      repeat (50000) @(posedge ref_clk);
      fail_count++;
      test_done();
   end
endmodule : frws_top_test
